// >>> logic/clock_gen_power_manager.sv
// Purpose: Phase clock generation, clock gating and power modes.
// Assumes: clk is the double-rate input clock; wake and requests are async pins.
// Notes: Slow clocks are one-cycle-accurate levels, all from flip-flops.
// Function
// R1 - Divide double-rate clock by two into two non-overlapping 50% phase clocks.
// R2 - Core and peripheral phase pairs are separately gateable.
// R3 - Idle freezes core phases one low, two high; peripherals keep running.
// R4 - Powerdown freezes core and peripheral phases, one low, two high.
// R5 - No DMA, refresh or hold grant while in Powerdown.
// R6 - Powerdown indicator driven on port three bit six pin.
// R7 - Programmable divider makes a prescaled clock for peripherals.
// R8 - Separate divide-by-two counter makes baud-rate generator clocks.
// R9 - Reset abandons everything and sets a defined state.
// R10 - Software picks Idle/Powerdown; interrupt or reset restarts clocks glitch free.
`timescale 1ns/1ns
`default_nettype none
module clock_gen_power_manager
    import clock_gen_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic idle_request,
    input wire logic powerdown_request,
    input wire logic wake_interrupt,
    input wire logic [PRESCALE_W-1:0] prescale_divisor,
    input wire logic dma_request,
    input wire logic refresh_request,
    input wire logic hold_request,
    input wire logic port_three_bit_six,
    input wire logic powerdown_pin_select,
    output logic core_phase_one,
    output logic core_phase_two,
    output logic periph_phase_one,
    output logic periph_phase_two,
    output logic prescaled_clock,
    output logic baud_clock,
    output logic sleep_indicator_out,
    output logic dma_grant,
    output logic refresh_grant,
    output logic hold_grant
);
    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers for pins
    logic [2:0] req_s1_r;
    logic [2:0] req_s2_r;
    logic wake_s1_r;
    logic wake_s2_r;
    logic [2:0] req_s1_nxt;
    logic [2:0] req_s2_nxt;
    logic wake_s1_nxt;
    logic wake_s2_nxt;

    // Only the second stage reads the first; a direct tap would pass metastable levels
    always_comb begin
        req_s1_nxt = {hold_request, refresh_request, dma_request};
        req_s2_nxt = req_s1_r;
        wake_s1_nxt = wake_interrupt;
        wake_s2_nxt = wake_s1_r;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            req_s1_r <= 3'h0;
            req_s2_r <= 3'h0;
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
        end else begin
            req_s1_r <= req_s1_nxt;
            req_s2_r <= req_s2_nxt;
            wake_s1_r <= wake_s1_nxt;
            wake_s2_r <= wake_s2_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Divide-by-two phase source and power mode
    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_IDLE = 3'h2,
        ST_POWERDOWN = 3'h4
    } power_state_t;

    power_state_t state_r;
    power_state_t state_nxt;
    logic phase_r;
    logic phase_nxt;

    always_comb begin
        phase_nxt = ~phase_r; // [R1]
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                // Mode change only at end of phase two so the frozen level is reached cleanly
                if (phase_r) begin
                    // Powerdown wins when both modes are asked for
                    if (powerdown_request) begin
                        state_nxt = ST_POWERDOWN; // [R10]
                    end else if (idle_request) begin
                        state_nxt = ST_IDLE; // [R10]
                    end
                end
            end
            ST_IDLE: begin
                // Peripherals never stopped, so only the core pair restarts
                if (wake_s2_r && phase_r) begin
                    state_nxt = ST_RUN; // [R10]
                end
            end
            ST_POWERDOWN: begin
                if (wake_s2_r && phase_r) begin
                    state_nxt = ST_RUN; // [R10]
                end
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r <= ST_RUN; // [R9]
            phase_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
        end
    end

    logic core_run;
    logic periph_run;
    logic in_powerdown;
    assign in_powerdown = (state_r == ST_POWERDOWN);
    assign core_run = (state_r == ST_RUN); // [R3]
    assign periph_run = !in_powerdown; // [R4]

    ////////////////////////////////////////////////////////////////////////
    // Gated phase pairs
    phase_pair_gate core_pair ( // [R2]
        .clk(clk),
        .nrst(nrst),
        .run(core_run),
        .phase_sel(phase_r),
        .ph_one(core_phase_one),
        .ph_two(core_phase_two)
    );

    phase_pair_gate periph_pair ( // [R2]
        .clk(clk),
        .nrst(nrst),
        .run(periph_run),
        .phase_sel(phase_r),
        .ph_one(periph_phase_one),
        .ph_two(periph_phase_two)
    );

    ////////////////////////////////////////////////////////////////////////
    // Prescaler and baud divide, clocked on peripheral phase
    logic [PRESCALE_W-1:0] pre_cnt_r;
    logic [PRESCALE_W-1:0] pre_cnt_nxt;
    logic prescaled_nxt;
    logic baud_nxt;
    logic periph_tick;

    // One tick per internal clock period, only while peripherals run
    assign periph_tick = periph_run && phase_r;

    // Counter stops with the peripheral pair, so the prescaled level freezes too
    // Divisor is read live; lowering it mid-count ends the current half at once
    always_comb begin
        pre_cnt_nxt = pre_cnt_r;
        prescaled_nxt = prescaled_clock;
        baud_nxt = baud_clock;
        if (periph_tick) begin
            baud_nxt = ~baud_clock; // [R8]
            if (pre_cnt_r >= prescale_divisor) begin
                pre_cnt_nxt = PRESCALE_RESET;
                prescaled_nxt = ~prescaled_clock; // [R7]
            end else begin
                pre_cnt_nxt = pre_cnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pre_cnt_r <= PRESCALE_RESET;
            prescaled_clock <= 1'b0;
            baud_clock <= 1'b0;
        end else begin
            pre_cnt_r <= pre_cnt_nxt;
            prescaled_clock <= prescaled_nxt;
            baud_clock <= baud_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Grants and powerdown pin
    logic [2:0] grant_nxt;
    logic sleep_nxt;

    // Three-edge lag from the request pins to the grants: two sync stages plus the output register
    always_comb begin
        grant_nxt = in_powerdown ? 3'h0 : req_s2_r; // [R5]
        // Pin shows port value unless the powerdown function is selected
        sleep_nxt = powerdown_pin_select ? in_powerdown : port_three_bit_six; // [R6]
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            dma_grant <= 1'b0;
            refresh_grant <= 1'b0;
            hold_grant <= 1'b0;
            sleep_indicator_out <= 1'b0;
        end else begin
            dma_grant <= grant_nxt[0];
            refresh_grant <= grant_nxt[1];
            hold_grant <= grant_nxt[2];
            sleep_indicator_out <= sleep_nxt;
        end
    end
endmodule : clock_gen_power_manager
`default_nettype wire

// >>> logic/clock_gen_pkg.sv
// Purpose: Constants shared by the clock generation and power manager.
// Assumes: Single clk domain at 25 MHz; prescaler width fixed.
// Notes: Mode encodings and divider widths live here.
package clock_gen_pkg;
    localparam int PRESCALE_W = 8;
    localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 8'h00;
    localparam logic [1:0] MODE_RUN = 2'h0;
    localparam logic [1:0] MODE_IDLE = 2'h1;
    localparam logic [1:0] MODE_POWERDOWN = 2'h2;
    localparam logic PHASE_ONE_FROZEN = 1'b0;
    localparam logic PHASE_TWO_FROZEN = 1'b1;
endpackage : clock_gen_pkg

// >>> logic/phase_pair_gate.sv
// Purpose: One gateable pair of phase clocks.
// Assumes: Phase inputs come from the shared divide-by-two stage.
// Notes: Gate is applied at the phase-one low point so the pair freezes cleanly.
`timescale 1ns/1ns
`default_nettype none
module phase_pair_gate
    import clock_gen_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic phase_sel,
    output logic ph_one,
    output logic ph_two
);
    logic ph_one_nxt;
    logic ph_two_nxt;

    always_comb begin
        ph_one_nxt = PHASE_ONE_FROZEN;
        ph_two_nxt = PHASE_TWO_FROZEN;
        // Frozen state equals the half where phase one is low, so stop/resume is glitch free
        if (run) begin
            ph_one_nxt = phase_sel;
            ph_two_nxt = ~phase_sel;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ph_one <= PHASE_ONE_FROZEN;
            ph_two <= PHASE_TWO_FROZEN;
        end else begin
            ph_one <= ph_one_nxt;
            ph_two <= ph_two_nxt;
        end
    end
endmodule : phase_pair_gate
`default_nettype wire

// >>> test/clk_source.sv
// Purpose: External oscillator feeding the double-rate clock.
// Assumes: 25 MHz, free running.
// Notes: Runs from time zero so reset can be sampled.
`timescale 1ns/1ns
`default_nettype none
module clk_source (
    output logic clk
);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
endmodule : clk_source
`default_nettype wire

// >>> test/clock_gen_monitor.sv
// Purpose: Port checker for the clock manager.
// Assumes: One clk domain, nrst synchronous active low.
// Notes: Run state inferred from peripheral phase activity.
`timescale 1ns/1ns
`default_nettype none
module clock_gen_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic dma_request,
    input wire logic port_three_bit_six,
    input wire logic powerdown_pin_select,
    input wire logic core_phase_one,
    input wire logic core_phase_two,
    input wire logic periph_phase_one,
    input wire logic periph_phase_two,
    input wire logic prescaled_clock,
    input wire logic baud_clock,
    input wire logic sleep_indicator_out,
    input wire logic dma_grant,
    input wire logic refresh_grant,
    input wire logic hold_grant
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence run_s; $rose(periph_phase_one); endsequence
    sequence dma_held_s; dma_request [*6]; endsequence
    // Two samples deep so mode entry and exit edges are skipped
    sequence asleep_s;
        powerdown_pin_select && $past(powerdown_pin_select)
            && sleep_indicator_out && $past(sleep_indicator_out);
    endsequence
    core_pair_a: assert property (core_phase_one != core_phase_two)
        else $error("core pair not complementary");
    periph_pair_a: assert property (periph_phase_one != periph_phase_two)
        else $error("peripheral pair not complementary");
    core_pulse_a: assert property ($rose(core_phase_one) |=> $fell(core_phase_one))
        else $error("core phase one high too long");
    periph_pulse_a: assert property ($rose(periph_phase_one) |=> $fell(periph_phase_one))
        else $error("peripheral phase one high too long");
    baud_rate_a: assert property ($changed(baud_clock) |=> $stable(baud_clock))
        else $error("baud clock faster than one tick");
    sleep_frozen_a: assert property (asleep_s |-> !core_phase_one && !periph_phase_one)
        else $error("phase clock running in powerdown");
    sleep_no_grant_a: assert property (asleep_s |-> !(dma_grant || refresh_grant || hold_grant))
        else $error("grant given in powerdown");
    pin_share_a: assert property (!$past(powerdown_pin_select)
        |-> sleep_indicator_out == $past(port_three_bit_six))
        else $error("shared pin wrong when deselected");
    grant_follow_a: assert property (dma_held_s ##0 run_s |-> dma_grant)
        else $error("held request not granted");
    reset_state_a: assert property (disable iff (1'b0) !nrst |=> core_phase_two
        && periph_phase_two && !baud_clock && !prescaled_clock && !dma_grant)
        else $error("reset state wrong");
endmodule : clock_gen_monitor
bind clock_gen_power_manager clock_gen_monitor chk (.*);
`default_nettype wire

// >>> test/clock_gen_power_manager_bench.sv
// Purpose: Self-checking bench for the clock manager.
// Assumes: Inputs change at falling edges.
// Notes: Expected rates derived from the divisor.
`timescale 1ns/1ns
`default_nettype none
module clock_gen_power_manager_bench;
    import clock_gen_pkg::*;
    logic clk, nrst, idle_request, powerdown_request, wake_interrupt, dma_request;
    logic refresh_request, hold_request, port_three_bit_six, powerdown_pin_select;
    logic [PRESCALE_W-1:0] prescale_divisor;
    logic core_phase_one, core_phase_two, periph_phase_one, periph_phase_two;
    logic prescaled_clock, baud_clock, sleep_indicator_out, dma_grant, refresh_grant, hold_grant;
    int bad_count = 0;
    int samples_checked = 0;
    int n;
    clk_source osc (.clk(clk));
    clock_gen_power_manager uut (.*);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    // Cycles until s changes; a stuck output ends the run
    task automatic gap(ref logic s, output int n);
        logic v;
        v = s;
        n = 0;
        while (s === v) begin
            @(negedge clk);
            n++;
            if (n > 600) begin
                bad_count++;
                conclude();
            end
        end
    endtask : gap
    function automatic logic [7:0] outs();
        return {core_phase_one, core_phase_two, periph_phase_one, periph_phase_two,
            prescaled_clock, baud_clock, dma_grant, sleep_indicator_out};
    endfunction : outs
    // Grant reference: a request level shows up three edges later
    int req_q[$];
    logic [2:0] grant_exp = 3'h0;
    logic model_on = 1'b0;
    always @(posedge clk) begin
        if (!nrst) begin
            req_q = '{0, 0};
            grant_exp = 3'h0;
        end else begin
            req_q.push_back(int'({hold_request, refresh_request, dma_request}));
            grant_exp = 3'(req_q.pop_front());
        end
    end
    always @(negedge clk) begin
        if (model_on) begin
            check("grant model", {hold_grant, refresh_grant, dma_grant}, grant_exp);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, idle_request, powerdown_request, wake_interrupt, dma_request} = '0;
        {refresh_request, hold_request, port_three_bit_six} = '0;
        powerdown_pin_select = 1'b1;
        prescale_divisor = 8'($urandom(17) % 4);
        repeat (10) @(negedge clk);
        check("reset outputs", outs(), 8'h50);
        nrst = 1'b1;
        model_on = 1'b1;
        $display("test reset done");
        repeat (2) gap(periph_phase_one, n);
        check("phase half period", 8'(n), 8'h01);
        repeat (2) gap(baud_clock, n);
        check("baud half period", 8'(n), 8'h02);
        repeat (2) gap(prescaled_clock, n);
        check("prescale half period", 8'(n), 8'(2 * (prescale_divisor + 1)));
        {dma_request, refresh_request, hold_request} = 3'h7;
        repeat (5) @(negedge clk);
        check("grants in run", {dma_grant, refresh_grant, hold_grant}, 8'h07);
        $display("test rates done");
        idle_request = 1'b1;
        repeat (6) @(negedge clk);
        idle_request = 1'b0;
        check("idle core pair", {core_phase_one, core_phase_two}, 8'h01);
        gap(periph_phase_one, n);
        check("idle periph runs", 8'(n), 8'h01);
        check("idle core held", {core_phase_one, core_phase_two}, 8'h01);
        check("grants in idle", {dma_grant, refresh_grant, hold_grant}, 8'h07);
        wake_interrupt = 1'b1;
        repeat (2) gap(core_phase_one, n);
        check("core after wake", 8'(n), 8'h01);
        wake_interrupt = 1'b0;
        $display("test idle done");
        model_on = 1'b0;
        {idle_request, powerdown_request} = 2'h3;
        repeat (6) @(negedge clk);
        {idle_request, powerdown_request} = 2'h0;
        check("powerdown pairs", outs() & 8'hF1, 8'h51);
        check("grants in powerdown", {dma_grant, refresh_grant, hold_grant}, 8'h00);
        powerdown_pin_select = 1'b0;
        repeat (2) @(negedge clk);
        check("port bit on pin", sleep_indicator_out, 8'h00);
        port_three_bit_six = 1'b1;
        repeat (2) @(negedge clk);
        check("port bit high on pin", sleep_indicator_out, 8'h01);
        port_three_bit_six = 1'b0;
        powerdown_pin_select = 1'b1;
        wake_interrupt = 1'b1;
        repeat (2) gap(periph_phase_one, n);
        check("periph after wake", 8'(n), 8'h01);
        wake_interrupt = 1'b0;
        model_on = 1'b1;
        $display("test powerdown done");
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        check("mid-run reset", outs(), 8'h50);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        check("restart periph pair", {periph_phase_one, periph_phase_two}, 8'h02);
        @(negedge clk);
        check("grants after reset", {dma_grant, refresh_grant, hold_grant}, 8'h07);
        $display("test second reset done");
        conclude();
    end
endmodule : clock_gen_power_manager_bench
`default_nettype wire
